// ==== logic/windowed_watchdog_timer.sv ====
// windowed watchdog timer with avalon-mm register access and low-power handling
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - counter steps down about every 16384 oscillator periods, activated or not
// - stepping from 40h to 3Fh while activated issues a system reset
// - activation bit only set by software, cleared only by reset
// - reset loads control register with activation clear and counter 7Fh
// - hardware watchdog option keeps the watchdog always active
// - first step follows a write after a period-dependent delay
// - timebase picks constants; periodically one shortened prescaler period occurs
// - halt with irq enable 0, option 0: one step, then stop, no reset
// - external interrupt from that halt resumes counting after 256 or 4096 clocks
// - reset ending that halt returns the watchdog to disabled state, except with the hardware watchdog option
// - halt with irq enable 0 and halt-reset option 1 issues a reset
// - halt with irq enable 1 freezes counter; any interrupt resumes at once
// - reset ending active-halt resumes counting after 256 or 4096 clocks
// - writing activation set with top bit clear resets immediately
// - watchdog reset drives the reset pin low for about 500 ns
module windowed_watchdog_timer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic osc_div_tick_in,
  input wire logic [1:0] timebase_select_in,
  input wire logic osc_irq_enable_in,
  input wire logic halt_instr_in,
  input wire logic ext_irq_in,
  input wire logic osc_irq_in,
  input wire logic hw_watchdog_opt_in,
  input wire logic halt_reset_option_in,
  input wire logic long_wake_opt_in,
  output logic reset_n_out,
  output logic wd_halted_out
);
  import wdg_pkg::*;

  // the whole state of the block apart from the prescaler
  typedef struct packed {
    logic [1:0] hw_sync;
    logic [1:0] halt_opt_sync;
    logic [1:0] long_wake_sync;
    logic act;
    logic [6:0] cnt;
    mode_t mode;
    logic [12:0] dly;
    logic [5:0] pulse;
    logic rst_n;
    logic halted;
    logic wait_req;
    logic [7:0] rdata;
  } wdg_state_t;

  wdg_state_t s_q;
  wdg_state_t s_d;
  logic step;
  logic run;

  // the prescaler keeps running in normal mode and for the single halt step
  assign run = (s_q.mode == MODE_RUN) || (s_q.mode == MODE_HALT_ONE);

  wdg_prescaler u_prescaler (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .clk_en_in(clk_en_in),
    .osc_tick_in(osc_div_tick_in),
    .run_in(run),
    .timebase_select_in(timebase_select_in),
    .step_out(step)
  );

  // next-state logic: bus slave, counter, low-power modes and reset pulse
  always_comb begin
    logic hw_opt;
    logic halt_opt;
    logic req;
    logic take;
    logic hit;
    logic wr_hit;
    logic new_act;
    logic trip;
    logic [12:0] wake_last;
    hw_opt = s_q.hw_sync[1];
    halt_opt = s_q.halt_opt_sync[1];
    req = 1'b0;
    take = 1'b0;
    hit = 1'b0;
    wr_hit = 1'b0;
    new_act = 1'b0;
    trip = 1'b0;
    wake_last = s_q.long_wake_sync[1] ? WAKE_LONG_LAST : WAKE_SHORT_LAST;
    s_d = s_q;
    if (clk_en_in) begin
      // option straps come from pins, so they pass two flip-flops first
      s_d.hw_sync = {s_q.hw_sync[0], hw_watchdog_opt_in};
      s_d.halt_opt_sync = {s_q.halt_opt_sync[0], halt_reset_option_in};
      s_d.long_wake_sync = {s_q.long_wake_sync[0], long_wake_opt_in};

      // avalon slave: one wait cycle, then the access completes
      req = avs_read_in || avs_write_in;
      hit = (avs_address_in == WDG_CTRL_ADDR);
      take = req && !s_q.wait_req;
      wr_hit = take && avs_write_in && hit && avs_byteenable_in[BYTE_LANE];
      if (req && s_q.wait_req) begin
        s_d.wait_req = 1'b0;
        // unmapped addresses read as zero
        s_d.rdata = hit ? {s_q.act, s_q.cnt} : 8'h00;
      end else begin
        s_d.wait_req = 1'b1;
      end

      // counter: a software refresh wins over a step in the same cycle
      if (wr_hit) begin
        new_act = s_q.act | avs_writedata_in[ACT_BIT];
        s_d.act = new_act;
        s_d.cnt = avs_writedata_in[6:0];
        // top bit written clear while active: immediate software reset
        trip = (new_act || hw_opt) && !avs_writedata_in[TOP_BIT];
      end else if (step) begin
        s_d.cnt = s_q.cnt - 7'h01;
        // counter step resets are only issued in normal mode; the halt step is harmless
        trip = (s_q.act || hw_opt) && (s_q.cnt == CNT_TRIP) && (s_q.mode == MODE_RUN);
      end

      // low-power sequencing
      case (s_q.mode)
        MODE_RUN: begin
          if (halt_instr_in) begin
            if (osc_irq_enable_in) begin
              s_d.mode = MODE_ACTIVE_HALT;
            end else if (halt_opt) begin
              trip = 1'b1;
            end else begin
              s_d.mode = MODE_HALT_ONE;
            end
          end
        end
        MODE_HALT_ONE: begin
          if (ext_irq_in) begin
            s_d.mode = MODE_WAKE_DELAY;
            s_d.dly = 13'h0000;
          end else if (step) begin
            s_d.mode = MODE_HALT_STOP;
          end
        end
        MODE_HALT_STOP: begin
          if (ext_irq_in) begin
            s_d.mode = MODE_WAKE_DELAY;
            s_d.dly = 13'h0000;
          end
        end
        MODE_ACTIVE_HALT: begin
          if (osc_irq_in || ext_irq_in) begin
            s_d.mode = MODE_RUN;
          end
        end
        MODE_WAKE_DELAY: begin
          // counted in cpu clocks, taken here as the block clock
          if (s_q.dly >= wake_last) begin
            s_d.mode = MODE_RUN;
            s_d.dly = 13'h0000;
          end else begin
            s_d.dly = s_q.dly + 13'h0001;
          end
        end
        default: begin
          s_d.mode = MODE_RUN;
        end
      endcase

      // reset pulse on the pin; a second trip during the pulse is absorbed
      if (s_q.pulse != 6'h00) begin
        s_d.pulse = s_q.pulse - 6'h01;
      end else if (trip) begin
        s_d.pulse = RST_PULSE_CNT;
      end
      s_d.rst_n = (s_d.pulse == 6'h00);
      s_d.halted = (s_d.mode != MODE_RUN);
    end
  end

  // every reset comes back as a full restart: activation clear, count 7Fh, then the restart delay
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{
        hw_sync: 2'b00,
        halt_opt_sync: 2'b00,
        long_wake_sync: 2'b00,
        act: WDG_CTRL_RESET[ACT_BIT],
        cnt: WDG_CTRL_RESET[6:0],
        mode: MODE_WAKE_DELAY,
        dly: 13'h0000,
        pulse: 6'h00,
        rst_n: 1'b1,
        halted: 1'b1,
        wait_req: 1'b1,
        rdata: 8'h00
      };
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flip-flops
  assign avs_readdata_out = {24'h000000, s_q.rdata};
  assign avs_waitrequest_out = s_q.wait_req;
  assign reset_n_out = s_q.rst_n;
  assign wd_halted_out = s_q.halted;
endmodule
`default_nettype wire

// ==== logic/wdg_pkg.sv ====
// constants, encodings and timing for the windowed watchdog block
package wdg_pkg;

  // register map: the printed offset is an index, byte address is four times it
  localparam logic [7:0] WDG_CTRL_INDEX = 8'h2a;
  localparam logic [9:0] WDG_CTRL_ADDR = {WDG_CTRL_INDEX, 2'b00};
  localparam logic [7:0] WDG_CTRL_RESET = 8'h7f;
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int BYTE_LANE = 0;

  // counter trip point: stepping from this value clears the top bit
  localparam logic [6:0] CNT_TRIP = 7'h40;

  // prescaler figures: full period and unit in oscillator periods, short base in units of 64 periods
  localparam int PRESCALE_PERIOD = 16384;
  localparam int SHORT_BASE = 192;
  localparam int PERIOD_UNIT = 64;
  localparam logic [5:0] ACC_STEP = 6'h04;

  // clock and reset pulse timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] RST_PULSE_CNT = 6'(RST_PULSE_CYCLES);

  // restart delays after a wake-up, in cpu clocks
  localparam int WAKE_SHORT = 256;
  localparam int WAKE_LONG = 4096;
  localparam logic [12:0] WAKE_SHORT_LAST = 13'(WAKE_SHORT - 1);
  localparam logic [12:0] WAKE_LONG_LAST = 13'(WAKE_LONG - 1);

  // low-power state of the watchdog
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_HALT_ONE = 3'b001,
    MODE_HALT_STOP = 3'b010,
    MODE_ACTIVE_HALT = 3'b011,
    MODE_WAKE_DELAY = 3'b100
  } mode_t;

  // timebase dependent constants
  function automatic logic [5:0] tb_msb(input logic [1:0] sel);
    case (sel)
      2'h0: tb_msb = 6'h04;
      2'h1: tb_msb = 6'h08;
      2'h2: tb_msb = 6'h14;
      default: tb_msb = 6'h31;
    endcase
  endfunction

  function automatic logic [5:0] tb_lsb(input logic [1:0] sel);
    case (sel)
      2'h0: tb_lsb = 6'h3b;
      2'h1: tb_lsb = 6'h35;
      2'h2: tb_lsb = 6'h23;
      default: tb_lsb = 6'h36;
    endcase
  endfunction

endpackage

// ==== logic/wdg_prescaler.sv ====
// oscillator prescaler that paces the watchdog counter steps
`timescale 1ns/1ns
`default_nettype none
module wdg_prescaler (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic osc_tick_in,
  input wire logic run_in,
  input wire logic [1:0] timebase_select_in,
  output logic step_out
);
  import wdg_pkg::*;

  typedef struct packed {
    logic [13:0] pre;
    logic [5:0] acc;
    logic step;
  } pre_state_t;

  localparam logic [13:0] FULL_LAST = 14'(PRESCALE_PERIOD - 1);

  pre_state_t s_q;
  pre_state_t s_d;

  // period ends count oscillator ticks; every msb/4 periods one is shortened
  always_comb begin
    logic [6:0] acc_sum;
    logic [14:0] short_len;
    acc_sum = 7'h00;
    short_len = 15'h0000;
    s_d = s_q;
    if (clk_en_in) begin
      s_d.step = 1'b0;
      if (osc_tick_in && run_in) begin
        if (s_q.pre == 14'h0000) begin
          s_d.step = 1'b1;
          acc_sum = {1'b0, s_q.acc} + {1'b0, ACC_STEP};
          // timebase changes only take hold here, at a period end
          if (acc_sum >= {1'b0, tb_msb(timebase_select_in)}) begin
            s_d.acc = 6'(acc_sum - {1'b0, tb_msb(timebase_select_in)});
            short_len = 15'((SHORT_BASE + int'(tb_lsb(timebase_select_in))) * PERIOD_UNIT);
            s_d.pre = 14'(short_len - 15'h0001);
          end else begin
            s_d.acc = acc_sum[5:0];
            s_d.pre = FULL_LAST;
          end
        end else begin
          s_d.pre = s_q.pre - 14'h0001;
        end
      end
    end
  end

  // prescaler is never cleared by a write, so the first step after one lands anywhere in a period
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= '{pre: 14'h3fff, acc: 6'h00, step: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign step_out = s_q.step;
endmodule
`default_nettype wire

// ==== sim/wdg_checker_sva.sv ====
// port-level assertion checker for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wdg_checker (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic osc_irq_enable_in,
  input wire logic halt_instr_in,
  input wire logic osc_irq_in,
  input wire logic halt_reset_option_in,
  input wire logic reset_n_out,
  input wire logic wd_halted_out
);
  import wdg_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [6:0] low_q;
  logic [6:0] low_d;
  // length of the reset pulse; a counter, as 63 is too long to unroll
  always_comb low_d = reset_n_out ? 7'h00 : low_q + 7'h01;
  always_ff @(posedge mclk_in or posedge rst_in)
    if (rst_in) low_q <= 7'h00;
    else if (clk_en_in) low_q <= low_d;
  sequence s_wr_taken;
    avs_write_in && !avs_waitrequest_out && clk_en_in && avs_address_in == WDG_CTRL_ADDR && avs_byteenable_in[0];
  endsequence
  sequence s_run_halt;
    halt_instr_in && !wd_halted_out && clk_en_in;
  endsequence
  property p_wait_one; $fell(avs_waitrequest_out) |=> avs_waitrequest_out; endproperty
  property p_wait_cause; !avs_waitrequest_out |-> $past(avs_read_in) || $past(avs_write_in); endproperty
  property p_pulse_min; !reset_n_out && low_q < 7'h3e |=> !reset_n_out; endproperty
  property p_pulse_max; !reset_n_out |-> low_q <= 7'h3e; endproperty
  property p_soft_trip; s_wr_taken ##0 (avs_writedata_in[7] && !avs_writedata_in[6]) |=> !reset_n_out; endproperty
  property p_rd_upper; avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0; endproperty
  property p_rd_unmapped;
    avs_read_in && !avs_waitrequest_out && avs_address_in != WDG_CTRL_ADDR |-> avs_readdata_out == 32'h0;
  endproperty
  property p_active_halt; s_run_halt ##0 (osc_irq_enable_in && !osc_irq_in) |=> wd_halted_out; endproperty
  property p_halt_reset;
    s_run_halt ##0 (!osc_irq_enable_in && halt_reset_option_in && $past(halt_reset_option_in, 2)) |-> ##[1:3] !reset_n_out;
  endproperty
  property p_halt_stop;
    s_run_halt ##0 (!osc_irq_enable_in && !halt_reset_option_in && !$past(halt_reset_option_in, 2))
      |=> (wd_halted_out && reset_n_out)[*8];
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  a_wait_cause: assert property (p_wait_cause) else $error("waitrequest low without request");
  a_pulse_min: assert property (p_pulse_min) else $error("reset pulse too short");
  a_pulse_max: assert property (p_pulse_max) else $error("reset pulse too long");
  a_soft_trip: assert property (p_soft_trip) else $error("software trip gave no reset");
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_active_halt: assert property (p_active_halt) else $error("active halt not entered");
  a_halt_reset: assert property (p_halt_reset) else $error("halt gave no reset");
  a_halt_stop: assert property (p_halt_stop) else $error("quiet halt misbehaved");
endmodule
`default_nettype wire

// ==== sim/windowed_watchdog_timer_bench.sv ====
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ns
`default_nettype none
module windowed_watchdog_timer_bench;
  import wdg_pkg::*;
  logic mclk_in, rst_in, rd, wr, tick, osc_irq_enable, halt, ext, osc, hw, hro, wreq, rstn, hlt, ce, lw;
  logic [1:0] tb;
  logic [9:0] adr;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  int bad_count = 0, comparisons = 0, cyc = 0, n;
  // rows: address, byte enables, write data, expected control byte
  logic [53:0] rows [5] = '{{10'h0a8, 4'hf, 32'h55, 8'h55}, {10'h0a8, 4'he, 32'h7a, 8'h55},
    {10'h0ac, 4'hf, 32'h22, 8'h55}, {10'h0a8, 4'h1, 32'hffffff7f, 8'h7f}, {10'h0a8, 4'hf, 32'h3f, 8'h3f}};
  windowed_watchdog_timer DUT (.mclk_in(mclk_in), .rst_in(rst_in), .clk_en_in(ce), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .osc_div_tick_in(tick), .timebase_select_in(tb), .osc_irq_enable_in(osc_irq_enable),
    .halt_instr_in(halt), .ext_irq_in(ext), .osc_irq_in(osc), .hw_watchdog_opt_in(hw),
    .halt_reset_option_in(hro), .long_wake_opt_in(lw), .reset_n_out(rstn), .wd_halted_out(hlt));
  // 125 mhz clock
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  // hang guard, well above the two long trip waits
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon access held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    @(posedge mclk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    k = 0;
    // no wait limit of its own: only the hang guard ends a stuck access
    do begin
      @(posedge mclk_in);
      k++;
    end while (wreq !== 1'b0);
    chk("bus_latency", 2, k);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // bounded wait on halted (which=1) or reset pin; n holds cycles waited
  task automatic wait_sig(input bit which, input logic v, input int lim);
    n = 0;
    while ((which ? hlt : rstn) !== v && n < lim) begin
      @(posedge mclk_in);
      n++;
    end
  endtask
  task automatic do_reset();
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    wait_sig(1, 1'b0, 5000);
  endtask
  task automatic pulse_halt();
    halt <= 1'b1;
    @(posedge mclk_in);
    halt <= 1'b0;
  endtask
  initial begin
    {rd, wr, tick, osc_irq_enable, halt, ext, osc, hw, hro, lw} <= '0;
    ce <= 1'b1;
    tb <= 2'h0;
    adr <= 10'h0;
    wd <= 32'h0;
    be <= 4'h0;
    rst_in <= 1'b1;
    do_reset();
    chk("wake_delay", 1, n >= 250 && n < 270);
    bus(0, WDG_CTRL_ADDR, 0, 0);
    chk("ctrl_reset", 32'h7f, q);
    bus(0, 10'h0ac, 0, 0);
    chk("unmapped_read", 0, q);
    foreach (rows[i]) begin
      bus(1, rows[i][53:44], rows[i][39:8], rows[i][43:40]);
      bus(0, WDG_CTRL_ADDR, 0, 0);
      chk("row_read", {24'h0, rows[i][7:0]}, q);
      chk("row_no_trip", 1, rstn);
    end
    bus(1, WDG_CTRL_ADDR, 32'hff, 4'h1);
    bus(1, WDG_CTRL_ADDR, 32'h7f, 4'h1);
    bus(0, WDG_CTRL_ADDR, 0, 0);
    chk("act_sticky", 32'hff, q);
    bus(1, WDG_CTRL_ADDR, 32'h80, 4'h1);
    wait_sig(0, 1'b0, 5);
    chk("soft_trip", 0, rstn);
    wait_sig(0, 1'b1, 200);
    chk("pulse_len", 63, n);
    do_reset();
    bus(0, WDG_CTRL_ADDR, 0, 0);
    chk("act_cleared", 32'h7f, q);
    // every cycle is a prescaler tick, so cycles stand for oscillator periods
    tick <= 1'b1;
    bus(1, WDG_CTRL_ADDR, 32'hc1, 4'h1);
    wait_sig(0, 1'b0, 40000);
    chk("trip_time", 1, n >= 28032 && n <= 32790);
    bus(0, WDG_CTRL_ADDR, 0, 0);
    chk("trip_count", 32'hbf, q);
    do_reset();
    hro <= 1'b1;
    repeat (4) @(posedge mclk_in);
    pulse_halt();
    wait_sig(0, 1'b0, 5);
    chk("halt_reset", 0, rstn);
    hro <= 1'b0;
    do_reset();
    osc_irq_enable <= 1'b1;
    pulse_halt();
    @(posedge mclk_in);
    chk("active_halt", 1, hlt);
    osc <= 1'b1;
    @(posedge mclk_in);
    osc <= 1'b0;
    wait_sig(1, 1'b0, 4);
    chk("osc_wake", 0, hlt);
    osc_irq_enable <= 1'b0;
    // refresh right before halting, as software is expected to
    bus(1, WDG_CTRL_ADDR, 32'h7f, 4'h1);
    pulse_halt();
    repeat (20) @(posedge mclk_in);
    chk("halt_stop", 1, hlt & rstn);
    ext <= 1'b1;
    @(posedge mclk_in);
    ext <= 1'b0;
    // clock enable low freezes the wake delay, so the whole delay still follows
    ce <= 1'b0;
    repeat (100) @(posedge mclk_in);
    ce <= 1'b1;
    wait_sig(1, 1'b0, 400);
    chk("ext_wake", 1, n >= 250 && n < 262);
    lw <= 1'b1;
    do_reset();
    chk("long_wake", 1, n >= 4090 && n < 4110);
    lw <= 1'b0;
    // msb 8 keeps the second period full length, unlike the shortened one at msb 4
    hw <= 1'b1;
    tb <= 2'h1;
    do_reset();
    bus(1, WDG_CTRL_ADDR, 32'h41, 4'h1);
    wait_sig(0, 1'b0, 34000);
    chk("hw_trip", 0, rstn);
    chk("tb_trip_time", 1, n >= 32700 && n <= 32790);
    final_report();
  end
endmodule
bind windowed_watchdog_timer wdg_checker u_chk (.mclk_in, .rst_in, .clk_en_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
  .osc_irq_enable_in, .halt_instr_in, .osc_irq_in, .halt_reset_option_in, .reset_n_out, .wd_halted_out);
`default_nettype wire
